// ==== core/jbs_cfg.svh ====
`ifndef JBS_CFG_SVH
`define JBS_CFG_SVH
// chain and register sizes
`define JBS_CELLS      27
`define JBS_IR_W       3
`define JBS_ID_W       32
// instruction codes
`define JBS_IR_EXTEST  3'h0
`define JBS_IR_SAMPLE  3'h1
`define JBS_IR_IDCODE  3'h2
`define JBS_IR_PRIV    3'h3
// fixed pattern loaded into the instruction shifter on capture
`define JBS_IR_CAPTURE 3'h1
// bit n-1 of a cell vector holds boundary cell n
`define JBS_IN_MASK    27'h7302f81
`define JBS_OUT_MASK   27'h08aa054
`define JBS_CTL_MASK   27'h045502a
// cells watched by the checks
`define JBS_C_AUX_DO   23
`define JBS_C_AUX_EN   22
`define JBS_C_BFS      13
`define JBS_C_BFS_DIR  12
// identification defaults, values arbitrary
`define JBS_ID_VER     4'h1
`define JBS_ID_PART    16'h1234
`define JBS_ID_MFR     11'h2aa
`endif

// ==== core/jbs_pkg.sv ====
`default_nettype none
`include "jbs_cfg.svh"
package jbs_pkg;
	// test access controller states
	typedef enum logic [3:0] {
		S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR,
		S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR,
		S_PA_IR, S_EX2_IR, S_UPD_IR
	} jbs_state_e;
	// decoded instruction
	typedef enum logic [2:0] {
		I_EXTEST, I_SAMPLE, I_IDCODE, I_PRIV, I_BYPASS
	} jbs_instr_e;
	// one bit per boundary cell
	typedef logic [`JBS_CELLS-1:0] jbs_cells_t;
	// test port pins into the block
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jbs_tap_in_s;
	// test data out with its enable
	typedef struct packed {
		logic tdo;
		logic tdo_oe_n;
	} jbs_tap_out_s;
	// pad drive per cell position
	typedef struct packed {
		jbs_cells_t val;
		jbs_cells_t oe_n;
	} jbs_pad_out_s;
endpackage : jbs_pkg
`default_nettype wire

// ==== core/jbs_tap.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "jbs_cfg.svh"
// Behaviour
// - four pins: clock, mode, data in, out
// - extest, sample, idcode, bypass, private instruction
// - three-bit code; 1xx always selects bypass
// - idcode shifts a 32-bit value out
// - id: version, part, maker, lsb one
// - all digital pins in one chain
// - capture pins; drive pins under extest
// - 27 cells, 27 at tdi, control follows
// - control one drives pin, zero floats
// - direction cell one makes frame sync output
// - control cells have no pin
module jbs_tap #(
	parameter logic [3:0]  ID_VERSION = `JBS_ID_VER,  // arbitrary value
	parameter logic [15:0] ID_PART    = `JBS_ID_PART, // arbitrary value
	parameter logic [10:0] ID_MFR     = `JBS_ID_MFR   // arbitrary value
) (
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire jbs_pkg::jbs_tap_in_s tap_in,
	output var  jbs_pkg::jbs_tap_out_s tap_out,
	input  wire jbs_pkg::jbs_cells_t  pad_in,
	output var  jbs_pkg::jbs_pad_out_s pad_out,
	input  wire jbs_pkg::jbs_cells_t  core_ctl,
	output var  jbs_pkg::jbs_cells_t  core_in
);
	import jbs_pkg::*;
	localparam jbs_cells_t OUT_MASK = `JBS_OUT_MASK; // output cells
	localparam logic [`JBS_ID_W-1:0] ID_VALUE =
		{ID_VERSION, ID_PART, ID_MFR, 1'b1};

	// synchroniser stages for the test pins and pads
	logic         tck_s1_r, tck_s2_r, tck_s3_r;
	logic         tms_s1_r, tms_s2_r;
	logic         tdi_s1_r, tdi_s2_r;
	jbs_cells_t   pad_s1_r, pad_s2_r;
	// controller and scan registers
	jbs_state_e   state_r, state_nxt;
	logic [2:0]   ir_sh_r, ir_sh_nxt;       // instruction shifter
	logic [2:0]   ir_r, ir_nxt;             // active instruction
	logic         byp_r, byp_nxt;           // one-bit bypass
	logic [31:0]  id_sh_r, id_sh_nxt;       // identification shifter
	jbs_cells_t   bsr_r, bsr_nxt;           // boundary shifter
	jbs_cells_t   upd_r, upd_nxt;           // boundary update stage
	jbs_tap_out_s tap_out_nxt;
	jbs_pad_out_s pad_out_nxt;
	jbs_cells_t   core_in_nxt;
	jbs_cells_t   cap;                      // capture value per cell
	jbs_instr_e   instr;                    // decoded instruction
	logic         tck_rise, tck_fall;
	logic         dr_bit;                   // data register output bit

	// two flops on every outside input, three on the test clock
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tck_s1_r <= 1'b0;
			tck_s2_r <= 1'b0;
			tck_s3_r <= 1'b0;
			tms_s1_r <= 1'b1;
			tms_s2_r <= 1'b1;
			tdi_s1_r <= 1'b1;
			tdi_s2_r <= 1'b1;
			pad_s1_r <= '0;
			pad_s2_r <= '0;
		end
		else
		begin
			tck_s1_r <= tap_in.tck;
			tck_s2_r <= tck_s1_r;
			tck_s3_r <= tck_s2_r;
			tms_s1_r <= tap_in.tms;
			tms_s2_r <= tms_s1_r;
			tdi_s1_r <= tap_in.tdi;
			tdi_s2_r <= tdi_s1_r;
			pad_s1_r <= pad_in;
			pad_s2_r <= pad_s1_r;
		end
	end

	// test clock edges seen from the system clock
	assign tck_rise = tck_s2_r & ~tck_s3_r;
	assign tck_fall = ~tck_s2_r & tck_s3_r;

	// instruction decode, upper half is bypass
	always_comb
	begin
		case (ir_r)
			`JBS_IR_EXTEST: instr = I_EXTEST;
			`JBS_IR_SAMPLE: instr = I_SAMPLE;
			`JBS_IR_IDCODE: instr = I_IDCODE;
			`JBS_IR_PRIV:   instr = I_PRIV;
			default:        instr = I_BYPASS;
		endcase
	end

	// input cells take the pin, others the core value
	assign cap = (pad_s2_r & `JBS_IN_MASK)
		| (core_ctl & ~`JBS_IN_MASK);

	// bit presented to tdo while shifting data
	always_comb
	begin
		case (instr)
			I_EXTEST, I_SAMPLE: dr_bit = bsr_r[0];
			I_IDCODE:           dr_bit = id_sh_r[0];
			default:            dr_bit = byp_r;
		endcase
	end

	// controller transitions on each rising test clock
	always_comb
	begin
		state_nxt = state_r;
		if (tck_rise)
		begin
			case (state_r)
				S_TLR:    state_nxt = tms_s2_r ? S_TLR : S_RTI;
				S_RTI:    state_nxt = tms_s2_r ? S_SEL_DR : S_RTI;
				S_SEL_DR: state_nxt = tms_s2_r ? S_SEL_IR : S_CAP_DR;
				S_CAP_DR: state_nxt = tms_s2_r ? S_EX1_DR : S_SH_DR;
				S_SH_DR:  state_nxt = tms_s2_r ? S_EX1_DR : S_SH_DR;
				S_EX1_DR: state_nxt = tms_s2_r ? S_UPD_DR : S_PA_DR;
				S_PA_DR:  state_nxt = tms_s2_r ? S_EX2_DR : S_PA_DR;
				S_EX2_DR: state_nxt = tms_s2_r ? S_UPD_DR : S_SH_DR;
				S_UPD_DR: state_nxt = tms_s2_r ? S_SEL_DR : S_RTI;
				S_SEL_IR: state_nxt = tms_s2_r ? S_TLR : S_CAP_IR;
				S_CAP_IR: state_nxt = tms_s2_r ? S_EX1_IR : S_SH_IR;
				S_SH_IR:  state_nxt = tms_s2_r ? S_EX1_IR : S_SH_IR;
				S_EX1_IR: state_nxt = tms_s2_r ? S_UPD_IR : S_PA_IR;
				S_PA_IR:  state_nxt = tms_s2_r ? S_EX2_IR : S_PA_IR;
				S_EX2_IR: state_nxt = tms_s2_r ? S_UPD_IR : S_SH_IR;
				S_UPD_IR: state_nxt = tms_s2_r ? S_SEL_DR : S_RTI;
				default:  state_nxt = S_TLR;
			endcase
		end
	end

	// capture and shift on rise, update and tdo on fall
	always_comb
	begin
		ir_sh_nxt   = ir_sh_r;
		ir_nxt      = ir_r;
		byp_nxt     = byp_r;
		id_sh_nxt   = id_sh_r;
		bsr_nxt     = bsr_r;
		upd_nxt     = upd_r;
		tap_out_nxt = tap_out;
		// rising edge: capture or shift the selected path
		if (tck_rise)
		begin
			case (state_r)
				S_CAP_IR: ir_sh_nxt = `JBS_IR_CAPTURE;
				S_SH_IR:  ir_sh_nxt = {tdi_s2_r, ir_sh_r[2:1]};
				S_CAP_DR:
				begin
					byp_nxt   = 1'b0;
					id_sh_nxt = ID_VALUE;
					if (instr == I_EXTEST || instr == I_SAMPLE)
						bsr_nxt = cap;
				end
				S_SH_DR:
				begin
					byp_nxt   = tdi_s2_r;
					id_sh_nxt = {tdi_s2_r, id_sh_r[31:1]};
					// cell 27 takes tdi, cell 1 feeds tdo
					if (instr == I_EXTEST || instr == I_SAMPLE)
						bsr_nxt = {tdi_s2_r, bsr_r[26:1]};
				end
				default: ;
			endcase
		end
		// falling edge: update stages and drive tdo
		if (tck_fall)
		begin
			case (state_r)
				S_TLR:    ir_nxt = `JBS_IR_IDCODE;
				S_UPD_IR: ir_nxt = ir_sh_r;
				S_UPD_DR:
					if (instr == I_EXTEST || instr == I_SAMPLE)
						upd_nxt = bsr_r;
				default: ;
			endcase
			// tdo drives only in the two shift states
			tap_out_nxt.tdo = (state_r == S_SH_IR) ? ir_sh_r[0] : dr_bit;
			tap_out_nxt.tdo_oe_n =
				~(state_r == S_SH_IR || state_r == S_SH_DR);
		end
	end

	// pad drive: core in system mode, update stage in extest
	always_comb
	begin
		pad_out_nxt.val  = '0;
		pad_out_nxt.oe_n = '1;
		for (int i = 1; i < `JBS_CELLS; i++)
		begin
			// control cells own no pin, they steer cell i
			if (OUT_MASK[i])
			begin
				if (instr == I_EXTEST)
				begin
					pad_out_nxt.val[i]  = upd_r[i];
					pad_out_nxt.oe_n[i] = ~upd_r[i-1];
				end
				else
				begin
					pad_out_nxt.val[i]  = core_ctl[i];
					pad_out_nxt.oe_n[i] = ~core_ctl[i-1];
				end
			end
		end
		core_in_nxt = pad_s2_r & `JBS_IN_MASK;
	end

	// register every state group and every output
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r  <= S_TLR;
			ir_sh_r  <= '0;
			ir_r     <= `JBS_IR_IDCODE;
			byp_r    <= 1'b0;
			id_sh_r  <= '0;
			bsr_r    <= '0;
			upd_r    <= '0;
			tap_out  <= '{tdo: 1'b0, tdo_oe_n: 1'b1};
			pad_out  <= '{val: '0, oe_n: '1};
			core_in  <= '0;
		end
		else
		begin
			state_r  <= state_nxt;
			ir_sh_r  <= ir_sh_nxt;
			ir_r     <= ir_nxt;
			byp_r    <= byp_nxt;
			id_sh_r  <= id_sh_nxt;
			bsr_r    <= bsr_nxt;
			upd_r    <= upd_nxt;
			tap_out  <= tap_out_nxt;
			pad_out  <= pad_out_nxt;
			core_in  <= core_in_nxt;
		end
	end

	// tdo moves only after a falling test clock
	property p_tdo_on_fall;
		@(posedge sys_clk) disable iff (sys_rst)
		$changed(tap_out.tdo) |-> $past(tck_fall);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall)
		else $error("tdo changed without falling tck");

	// tms high in select-ir returns to reset
	property p_to_reset;
		@(posedge sys_clk) disable iff (sys_rst)
		(tck_rise && tms_s2_r && state_r == S_SEL_IR)
			|=> (state_r == S_TLR) && (ir_r == $past(ir_r));
	endproperty
	a_to_reset: assert property (p_to_reset)
		else $error("controller missed reset");

	// upper codes always decode to bypass
	property p_upper_bypass;
		@(posedge sys_clk) disable iff (sys_rst)
		ir_r[2] |-> instr == I_BYPASS;
	endproperty
	a_upper_bypass: assert property (p_upper_bypass)
		else $error("upper code not bypass");

	// private code selects the one-bit path
	property p_priv_bypass;
		@(posedge sys_clk) disable iff (sys_rst)
		(tck_rise && state_r == S_CAP_DR && instr == I_PRIV)
			|=> byp_r == 1'b0 ##0 dr_bit == 1'b0;
	endproperty
	a_priv_bypass: assert property (p_priv_bypass)
		else $error("private path wrong");

	// identification capture with lsb one
	property p_idcode;
		@(posedge sys_clk) disable iff (sys_rst)
		(tck_rise && state_r == S_CAP_DR && instr == I_IDCODE)
			|=> id_sh_r == ID_VALUE && dr_bit;
	endproperty
	a_idcode: assert property (p_idcode)
		else $error("identification capture wrong");

	// boundary shifts toward tdo, tdi enters cell 27
	property p_chain_shift;
		@(posedge sys_clk) disable iff (sys_rst)
		(tck_rise && state_r == S_SH_DR && instr == I_SAMPLE)
			|=> bsr_r == {$past(tdi_s2_r), $past(bsr_r[26:1])};
	endproperty
	a_chain_shift: assert property (p_chain_shift)
		else $error("boundary shift wrong");

	// extest drives the aux output from its cells
	property p_extest_drive;
		@(posedge sys_clk) disable iff (sys_rst)
		(instr == I_EXTEST) |=>
			pad_out.val[`JBS_C_AUX_DO] == $past(upd_r[`JBS_C_AUX_DO])
			&& pad_out.oe_n[`JBS_C_AUX_DO] == !$past(upd_r[`JBS_C_AUX_EN]);
	endproperty
	a_extest_drive: assert property (p_extest_drive)
		else $error("extest drive wrong");

	// direction cell steers the frame sync pin
	property p_dir_cell;
		@(posedge sys_clk) disable iff (sys_rst)
		(instr == I_EXTEST) |=>
			pad_out.oe_n[`JBS_C_BFS] == !$past(upd_r[`JBS_C_BFS_DIR]);
	endproperty
	a_dir_cell: assert property (p_dir_cell)
		else $error("direction cell ignored");

	// control cells never reach a pad
	property p_ctl_no_pin;
		@(posedge sys_clk) disable iff (sys_rst)
		((pad_out.val & `JBS_CTL_MASK) == '0)
			&& ((pad_out.oe_n & `JBS_CTL_MASK) == `JBS_CTL_MASK);
	endproperty
	a_ctl_no_pin: assert property (p_ctl_no_pin)
		else $error("control cell drives a pad");

	// tdo enabled only after a shift state
	property p_tdo_enable;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(tap_out.tdo_oe_n) |->
			$past(state_r == S_SH_DR || state_r == S_SH_IR);
	endproperty
	a_tdo_enable: assert property (p_tdo_enable)
		else $error("tdo enabled outside shift");

endmodule : jbs_tap
`default_nettype wire

// ==== sim/jbs_tester.sv ====
`timescale 1ns/1ns
`default_nettype none
// board tester model: drives the test port pins, reads tdo
module jbs_tester (
	input  wire logic             sys_clk,  // bench clock
	output var  jbs_pkg::jbs_tap_in_s  tap_in,  // tck, tms, tdi
	input  wire jbs_pkg::jbs_tap_out_s tap_out  // tdo and its enable
);
	import jbs_pkg::*;
	localparam int HALF = 6; // half of a 48 ns test clock

	// test clock parked low between frames
	initial tap_in = '0;

	// one test clock: set pins, read tdo, rise, fall
	task automatic pulse(input logic tms, input logic tdi,
		output logic tdo, output logic oe_n);
		@(posedge sys_clk);
		tap_in.tms <= tms;
		tap_in.tdi <= tdi;
		// low phase counts the edge waited above
		repeat (HALF - 1) @(posedge sys_clk);
		tdo = tap_out.tdo; // read before rise
		oe_n = tap_out.tdo_oe_n;
		tap_in.tck <= 1'b1;
		repeat (HALF) @(posedge sys_clk);
		tap_in.tck <= 1'b0;
	endtask : pulse

	// five mode-high clocks, then park in idle
	task automatic reset_tap();
		logic t;
		logic o;
		repeat (5) pulse(1'b1, 1'b0, t, o);
		pulse(1'b0, 1'b0, t, o);
	endtask : reset_tap

	// full scan from idle back to idle, lsb first
	task automatic scan(input bit ir, input int n, input logic [31:0] din,
		output logic [31:0] dout, output bit oe_ok);
		logic t;
		logic o;
		dout = '0;
		oe_ok = 1'b1;
		pulse(1'b1, 1'b0, t, o); // select data path
		if (ir)
			pulse(1'b1, 1'b0, t, o); // select instruction path
		pulse(1'b0, 1'b0, t, o); // capture
		pulse(1'b0, 1'b0, t, o); // enter shift
		for (int i = 0; i < n; i++)
		begin
			pulse(i == n - 1, din[i], dout[i], o);
			if (o !== 1'b0)
				oe_ok = 1'b0; // tdo must be driven while shifting
		end
		pulse(1'b1, 1'b0, t, o); // update
		pulse(1'b0, 1'b0, t, o); // back to idle
	endtask : scan
endmodule : jbs_tester
`default_nettype wire

// ==== sim/test_jtag_boundary_scan_tap.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "jbs_cfg.svh"
module test_jtag_boundary_scan_tap;
	import jbs_pkg::*;
	localparam logic [3:0]  VER  = 4'h5;    // arbitrary value
	localparam logic [15:0] PART = 16'h6b1d; // arbitrary value
	localparam logic [10:0] MFR  = 11'h355;  // arbitrary value
	localparam logic [31:0] ID   = {VER, PART, MFR, 1'b1};
	localparam jbs_cells_t  IN_M  = `JBS_IN_MASK;  // input cells
	localparam jbs_cells_t  OUT_M = `JBS_OUT_MASK; // output cells
	logic         sys_clk;  // 250 MHz
	logic         sys_rst;  // async, active high
	jbs_tap_in_s  tap_in;   // from tester model
	jbs_tap_out_s tap_out;  // to tester model
	jbs_cells_t   pad_in;   // pad levels
	jbs_cells_t   core_ctl; // functional drive
	jbs_cells_t   core_in;  // synced pads
	jbs_pad_out_s pad_out;  // pad drive
	int           bad_count;
	int           checked;
	int           seed = 32'h72a662ea;
	logic [31:0]  din;      // shifted in
	logic [31:0]  dout;     // shifted out
	logic [31:0]  exp_v;    // model result
	bit           oe_ok;    // tdo enabled all shift long
	jbs_cells_t   cap;      // expected capture

	// clock
	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;

	jbs_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .tap_in(tap_in),
		.tap_out(tap_out), .pad_in(pad_in), .pad_out(pad_out),
		.core_ctl(core_ctl), .core_in(core_in));
	jbs_tester u_tst (.sys_clk(sys_clk), .tap_in(tap_in), .tap_out(tap_out));

	// compare and count
	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", what, e, g);
			bad_count++;
		end
	endtask : check

	// pad drive from a cell vector: value and enable of next cell
	task automatic check_pads(input jbs_cells_t src);
		check("pad value", {5'h0, src & OUT_M}, {5'h0, pad_out.val});
		check("pad enable", {5'h0, ~((src << 1) & OUT_M)},
			{5'h0, pad_out.oe_n});
	endtask : check_pads

	// new random pads and core drive, then let them settle
	task automatic rnd();
		@(posedge sys_clk);
		pad_in <= 27'($random(seed));
		core_ctl <= 27'($random(seed));
		repeat (6) @(posedge sys_clk);
		check("core input", {5'h0, pad_in & IN_M}, {5'h0, core_in});
	endtask : rnd

	task automatic print_verdict();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// hang guard
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		$display("MISMATCH run length expected end seen hang");
		bad_count++;
		print_verdict();
	end

	// main sequence
	initial
	begin
		bad_count = 0;
		checked = 0;
		sys_rst = 1'b1;
		pad_in = '0;
		core_ctl = '0;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rnd();
		check_pads(core_ctl);
		check("tdo idle", 32'h1, {31'h0, tap_out.tdo_oe_n});
		u_tst.reset_tap();
		u_tst.scan(1'b0, 32, 32'h0, dout, oe_ok);
		check("idcode", ID, dout);
		// every instruction code, random shift data
		for (int c = 0; c < 8; c++)
		begin
			rnd();
			u_tst.scan(1'b1, 3, {29'h0, 3'(c)}, dout, oe_ok);
			check("ir capture", 32'h1, {29'h0, dout[2:0]});
			din = $random(seed);
			cap = (pad_in & IN_M) | (core_ctl & ~IN_M);
			u_tst.scan(1'b0, 32, din, dout, oe_ok);
			case (c)
				0, 1: exp_v = {din[4:0], cap}; // chain of 27
				2: exp_v = ID;
				default: exp_v = {din[30:0], 1'b0}; // one-bit path
			endcase
			check("data scan", exp_v, dout);
			check("tdo driven", 32'h1, {31'h0, oe_ok});
			if (c == 0)
				check_pads(din[31:5]);
			else
				check_pads(core_ctl);
		end
		// mode-high reset brings idcode back
		u_tst.reset_tap();
		u_tst.scan(1'b0, 32, 32'h0, dout, oe_ok);
		check("idcode again", ID, dout);
		print_verdict();
	end
endmodule : test_jtag_boundary_scan_tap
`default_nettype wire
